// ---- rtl/rx_char_buffer.sv ----
// Eight-deep receive character buffer.
// Assumes push is never issued while full; the core turns that into overrun.
`timescale 1ns/1ps
module rx_char_buffer #(
  parameter int DEPTH = 8
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  rx_fifo_if.buf_side f
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH != 8) $error("rx_char_buffer: depth must be 8");
  end

  logic [8:0]    mem [DEPTH]; // R16
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;

  assign f.count = cnt_r;
  assign f.head  = mem[rd_r];
  assign f.full  = (cnt_r == (AW+1)'(DEPTH));

  // Flush wins over traffic so a cleared overrun leaves an empty buffer.
  always_ff @(posedge clk_i) begin
    if (rst_i || f.flush) begin // R13
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (f.push && !f.full) begin
        mem[wr_r] <= f.data;
        wr_r      <= wr_r + AW'(1);
      end
      if (f.pop && cnt_r != '0) begin
        rd_r <= rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(f.push && !f.full) - (AW+1)'(f.pop && cnt_r != '0);
    end
  end
endmodule : rx_char_buffer

// ---- rtl/rx_fifo_if.sv ----
// Interface carrying received characters from the receiver core to the buffer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface rx_fifo_if;
  logic       push;
  logic [8:0] data;
  logic       pop;
  logic       flush;
  logic [3:0] count;
  logic [8:0] head;
  logic       full;

  modport core (output push, output data, output pop, output flush, input count, input head, input full);
  modport buf_side (input push, input data, input pop, input flush, output count, output head, output full);
endinterface : rx_fifo_if

// ---- rtl/uart_rx_mode_status.sv ----
// Receive-side mode and status block of an asynchronous serial port.
// Assumes a classic Wishbone master on clk_i and a raw asynchronous receive pin.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module uart_rx_mode_status (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_rx_line_i,
  output logic             irq_o
);
  rx_fifo_if fq ();
  rx_char_buffer #(.DEPTH(8)) u_buf (.clk_i(clk_i), .rst_i(rst_i), .f(fq));

  // Software state.
  logic [31:0] mode_r;
  logic [1:0]  thr_r;
  logic        addr_en_r;
  logic        ien_r;
  logic [15:0] div_r;
  logic        ovr_r;
  logic        parity_fault_flag_r;
  logic        framing_fault_flag_r;
  logic        ack_r;
  logic        par_bad_r;

  wire on_w     = mode_r[uart_rx_pkg::ON_BIT];
  wire auto_w   = mode_r[uart_rx_pkg::AUTO_BIT];
  wire inv_w    = mode_r[uart_rx_pkg::INV_BIT];
  wire fast_w   = mode_r[uart_rx_pkg::FAST_BIT];
  wire two_stop = mode_r[uart_rx_pkg::STOP_BIT];
  wire [1:0] fmt_w = mode_r[uart_rx_pkg::FMT_LSB +: 2];

  // Bus decode.
  wire req_w    = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr_w     = req_w && wb_we_i;
  wire wr_mode  = wr_w && wb_adr_i == uart_rx_pkg::MODE_ADDR;
  wire wr_stat  = wr_w && wb_adr_i == uart_rx_pkg::STATUS_ADDR;
  wire wr_div   = wr_w && wb_adr_i == uart_rx_pkg::DIV_ADDR;
  wire rd_data  = req_w && !wb_we_i && wb_adr_i == uart_rx_pkg::DATA_ADDR;

  // Pin synchroniser: three flops, a change counts when the last two agree.
  logic [2:0] sync_r;
  logic       line_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 3'h7;
      line_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], serial_rx_line_i};
      if (sync_r[2] == sync_r[1]) line_r <= sync_r[1] ^ inv_w; // R3
    end
  end
  // Line is normalised so that idle is one whatever the polarity.

  // Oversample tick from the divider; the ratio picks samples per bit.
  logic [15:0] tick_cnt_r;
  wire         tick_w = (tick_cnt_r == 16'h0000);
  always_ff @(posedge clk_i) begin
    if (rst_i || !on_w) tick_cnt_r <= 16'h0000;
    else if (tick_w)    tick_cnt_r <= div_r;
    else                tick_cnt_r <= tick_cnt_r - 16'h0001;
  end
  wire [4:0] ovs_w = fast_w ? 5'(uart_rx_pkg::OVS_FAST) : 5'(uart_rx_pkg::OVS_STD); // R4

  // Receive state machine.
  uart_rx_pkg::rx_state_t st_r, st_nxt;
  logic [4:0]  os_r;
  logic [3:0]  bit_r;
  logic [8:0]  rx_shift_register_r;
  logic        stop2_r;
  logic [19:0] meas_r;

  wire nine_w    = fmt_w == uart_rx_pkg::FMT_9N;
  wire par_en    = fmt_w == uart_rx_pkg::FMT_8E || fmt_w == uart_rx_pkg::FMT_8O;
  wire [3:0] nbits_w = nine_w ? 4'h9 : 4'h8; // R5
  wire mid_w     = tick_w && os_r == (ovs_w >> 1);
  wire end_w     = tick_w && os_r == ovs_w - 5'h01;
  wire par_calc  = ^rx_shift_register_r[7:0] ^ (fmt_w == uart_rx_pkg::FMT_8O); // R5
  wire ovr_clr   = wr_stat && wb_sel_i[0] && ovr_r && !wb_dat_i[uart_rx_pkg::OVR_BIT];

  // Next-state selection for the receiver.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      uart_rx_pkg::RX_IDLE:  if (!line_r) st_nxt = auto_w ? uart_rx_pkg::RX_AUTO : uart_rx_pkg::RX_START;
      uart_rx_pkg::RX_START: if (mid_w) st_nxt = line_r ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
      uart_rx_pkg::RX_DATA:  if (mid_w && bit_r == nbits_w - 4'h1)
                               st_nxt = par_en ? uart_rx_pkg::RX_PAR : uart_rx_pkg::RX_STOP;
      uart_rx_pkg::RX_PAR:   if (mid_w) st_nxt = uart_rx_pkg::RX_STOP;
      uart_rx_pkg::RX_STOP:  if (mid_w && (!two_stop || stop2_r || !line_r)) st_nxt = uart_rx_pkg::RX_IDLE; // R6
      uart_rx_pkg::RX_AUTO:  if (bit_r == 4'h5 && line_r) st_nxt = uart_rx_pkg::RX_IDLE;
      default:               st_nxt = uart_rx_pkg::RX_IDLE;
    endcase
  end

  // Auto-rate: count clocks across start plus seven bits of 0x55 (four falling edges).
  wire meas_done = st_r == uart_rx_pkg::RX_AUTO && bit_r == 4'h5 && line_r; // R1
  wire [19:0] per_bit = meas_r >> 3;
  wire [19:0] per_tick = fast_w ? (per_bit >> 2) : (per_bit >> 4);
  logic prev_line_r;

  // Character completion and its checks.
  wire in_stop   = st_r == uart_rx_pkg::RX_STOP && mid_w;
  wire char_done = in_stop && st_nxt == uart_rx_pkg::RX_IDLE;
  wire frame_bad = in_stop && !line_r; // R11
  wire keep_w    = !(addr_en_r && nine_w) || rx_shift_register_r[8]; // R8
  wire push_w    = char_done && keep_w;

  assign fq.push  = push_w && !fq.full;
  assign fq.data  = nine_w ? rx_shift_register_r : {1'b0, rx_shift_register_r[7:0]};
  assign fq.pop   = rd_data;
  assign fq.flush = ovr_clr || !on_w; // R13

  // Receiver datapath; clearing overrun also empties the shift register.
  always_ff @(posedge clk_i) begin
    if (rst_i || !on_w || ovr_clr) begin // R13
      st_r <= uart_rx_pkg::RX_IDLE;
      os_r <= 5'h00;
      bit_r <= 4'h0;
      rx_shift_register_r <= 9'h000;
      stop2_r <= 1'b0;
      meas_r <= 20'h00000;
      prev_line_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      prev_line_r <= line_r;
      if (st_r == uart_rx_pkg::RX_IDLE) begin
        os_r <= 5'h00;
        bit_r <= 4'h0;
        stop2_r <= 1'b0;
        meas_r <= 20'h00000;
      end else if (st_r == uart_rx_pkg::RX_AUTO) begin
        if (bit_r != 4'h4) meas_r <= meas_r + 20'h00001;
        if (prev_line_r && !line_r) bit_r <= bit_r + 4'h1;
        if (bit_r == 4'h4 && !prev_line_r && line_r) bit_r <= 4'h5;
      end else if (tick_w) begin
        os_r <= end_w ? 5'h00 : os_r + 5'h01;
        if (mid_w && st_r == uart_rx_pkg::RX_DATA) begin
          rx_shift_register_r <= nine_w ? {line_r, rx_shift_register_r[8:1]}
                                        : {1'b0, line_r, rx_shift_register_r[7:1]};
          bit_r <= bit_r + 4'h1;
        end
        if (mid_w && st_r == uart_rx_pkg::RX_STOP) stop2_r <= 1'b1;
      end
    end
  end

  // Registers: per-character error flags follow the last completed character.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r    <= uart_rx_pkg::MODE_RST;
      thr_r     <= uart_rx_pkg::THR_ANY;
      addr_en_r <= 1'b0;
      ien_r     <= 1'b0;
      div_r     <= uart_rx_pkg::DIV_RST;
      ovr_r     <= 1'b0;
      parity_fault_flag_r    <= 1'b0;
      framing_fault_flag_r    <= 1'b0;
    end else begin
      if (wr_mode && wb_sel_i[0]) mode_r[7:0]  <= wb_dat_i[7:0];
      if (wr_mode && wb_sel_i[1]) mode_r[15:8] <= wb_dat_i[15:8];
      if (meas_done) begin
        mode_r[uart_rx_pkg::AUTO_BIT] <= 1'b0; // R2
        div_r <= (per_tick[15:0] == 16'h0000) ? 16'h0000 : per_tick[15:0] - 16'h0001;
      end else if (wr_div) begin
        div_r <= wb_dat_i[15:0];
      end
      if (wr_stat && wb_sel_i[0]) begin
        thr_r     <= wb_dat_i[uart_rx_pkg::THR_LSB +: 2];
        addr_en_r <= wb_dat_i[uart_rx_pkg::ADDR_BIT];
      end
      if (wr_stat && wb_sel_i[1]) ien_r <= wb_dat_i[uart_rx_pkg::IEN_BIT];
      // Overflow sets win over a software clear in the same cycle.
      if (push_w && fq.full)  ovr_r <= 1'b1; // R12
      else if (ovr_clr)       ovr_r <= 1'b0; // R12
      if (char_done || frame_bad) begin
        parity_fault_flag_r <= par_en && par_bad_r; // R10
        framing_fault_flag_r <= frame_bad; // R11
      end
    end
  end

  // Parity bit is sampled separately so the check sees data and parity together.
  always_ff @(posedge clk_i) begin
    if (rst_i || st_r == uart_rx_pkg::RX_IDLE) par_bad_r <= 1'b0;
    else if (st_r == uart_rx_pkg::RX_PAR && mid_w) par_bad_r <= (line_r != par_calc); // R10
  end

  // Threshold compare; code 11 is reserved and treated as non-empty.
  wire irq_lvl = (thr_r == uart_rx_pkg::THR_3Q)   ? (fq.count >= 4'(uart_rx_pkg::FILL_3Q)) :
                 (thr_r == uart_rx_pkg::THR_HALF) ? (fq.count >= 4'(uart_rx_pkg::FILL_HALF)) :
                 (fq.count != 4'h0); // R7
  assign irq_o = ien_r && (irq_lvl || ovr_r);

  wire idle_w = st_r == uart_rx_pkg::RX_IDLE; // R9
  wire avail_w = fq.count != 4'h0; // R14
  wire [31:0] stat_w = {23'h0, ien_r, thr_r, addr_en_r, idle_w, parity_fault_flag_r, framing_fault_flag_r, ovr_r, avail_w};

  // Read data mux; unmapped addresses read zero and still acknowledge.
  wire [31:0] rd_mux = (wb_adr_i == uart_rx_pkg::MODE_ADDR)   ? mode_r :
                       (wb_adr_i == uart_rx_pkg::STATUS_ADDR) ? stat_w :
                       (wb_adr_i == uart_rx_pkg::DATA_ADDR)   ? {23'h0, fq.head} :
                       (wb_adr_i == uart_rx_pkg::DIV_ADDR)    ? {16'h0, div_r} : 32'h0;

  // One-cycle ack, one wait state after the strobe; software keeps R15 spacing itself.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_r    <= req_w;
      if (req_w) wb_dat_o <= rd_mux;
    end
  end
  assign wb_ack_o = ack_r;
endmodule : uart_rx_mode_status

// ---- rtl/uart_rx_pkg.sv ----
// Package for the receive-side mode and status block of an asynchronous serial port.
// Assumes a classic Wishbone master with 32-bit data and a 100 MHz bus clock.
//
// Contract
// R1: Auto-rate enable measures bit time from the next 0x55 sync character.
// R2: Hardware clears the auto-rate enable when measurement completes.
// R3: Polarity invert set means idle receive line is 0, else 1.
// R4: Fast oversample select gives 4x baud clock, else 16x.
// R5: Format 11 nine bits, 10 odd parity, 01 even parity, 00 eight plain.
// R6: Stop select set means two stop bits, else one; far end must match.
// R7: Receive interrupt at 6+, 4+ or non-empty by threshold code; 11 unused.
// R8: Address detect keeps only ninth-bit-set characters, only in nine-bit format.
// R9: Receiver idle flag reads one when idle, zero while receiving.
// R10: Parity fault flag reads one when current character had parity error.
// R11: Framing fault flag reads one when current character had framing error.
// R12: Overrun flag set on buffer overflow; only software clears it by writing zero.
// R13: Clearing a set overrun flag empties buffer and receive shift register.
// R14: Data available flag reads one while buffer holds an unread character.
// R15: Software avoids register access in the cycle after turning module off.
// R16: Receive buffer holds eight characters.
package uart_rx_pkg;

  // Word byte addresses.
  localparam logic [3:0] MODE_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] DATA_ADDR   = 4'h8;
  localparam logic [3:0] DIV_ADDR    = 4'hC;

  // Mode register fields.
  localparam int STOP_BIT    = 0;
  localparam int FMT_LSB     = 1;
  localparam int FAST_BIT    = 3;
  localparam int INV_BIT     = 4;
  localparam int AUTO_BIT    = 5;
  localparam int ON_BIT      = 15;

  // Status register fields.
  localparam int AVAIL_BIT   = 0;
  localparam int OVR_BIT     = 1;
  localparam int FRAME_BIT   = 2;
  localparam int PAR_BIT     = 3;
  localparam int IDLE_BIT    = 4;
  localparam int ADDR_BIT    = 5;
  localparam int THR_LSB     = 6;
  localparam int IEN_BIT     = 8;

  // Reset values.
  localparam logic [31:0] MODE_RST   = 32'h0000_0000;
  localparam logic [15:0] DIV_RST    = 16'h0035;

  // Frame formats.
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_9N = 2'h3;

  // Threshold codes and fill levels.
  localparam logic [1:0] THR_ANY  = 2'h0;
  localparam logic [1:0] THR_HALF = 2'h1;
  localparam logic [1:0] THR_3Q   = 2'h2;
  localparam int         FILL_HALF = 4;
  localparam int         FILL_3Q   = 6;

  // Oversampling ratios and the sync character.
  localparam int         OVS_FAST = 4;
  localparam int         OVS_STD  = 16;
  localparam logic [7:0] SYNC_CHAR = 8'h55;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b011,
    RX_PAR   = 3'b010,
    RX_STOP  = 3'b110,
    RX_AUTO  = 3'b111
  } rx_state_t;

endpackage : uart_rx_pkg

// ---- tb/serial_tx_model.sv ----
// Remote transmitter that drives the receive line one frame at a time.
// Assumes the bench programs a divider that matches BIT_CLKS.
`timescale 1ns/1ps
module serial_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_i,
  input  wire logic invert_i,
  output logic      line_o
);
  logic bit_r = 1'b1;
  // The line is always driven; between frames it rests at the mark level.
  assign line_o = bit_r ^ invert_i;
  task automatic put(input logic v);
    @(posedge clk_i);
    bit_r <= v;
    repeat (BIT_CLKS - 1) @(posedge clk_i);
  endtask : put
  // Parity 0 none, 1 even, 2 odd; no stop bits sends one low stop bit instead.
  task automatic send(input logic [8:0] d, input int nb, input int pm, input int st);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (pm != 0) put(^d[7:0] ^ (pm == 2));
    if (st == 0) put(1'b0);
    for (int i = 0; i < st; i++) put(1'b1);
    bit_r <= 1'b1;
  endtask : send
endmodule : serial_tx_model

// ---- tb/uart_rx_mode_status_properties.sv ----
// Checker of the receive mode and status block, bound to its top module.
// Assumes the single-cycle Wishbone master of the bench on clk_i.
`timescale 1ns/1ps
module uart_rx_mode_status_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_rx_line_i,
  input wire logic        irq_o
);
  logic        ien_r;
  logic        ovr_r;
  logic        auto_off_r;
  logic [31:0] mode_r;
  wire         wr_a = wb_ack_o && wb_we_i;
  wire         rd_a = wb_ack_o && !wb_we_i;
  wire         st_a = wb_adr_i == uart_rx_pkg::STATUS_ADDR;
  wire         md_a = wb_adr_i == uart_rx_pkg::MODE_ADDR;
  // Shadows follow the ack edge, one cycle behind the block, so checks allow for that lag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_r <= 1'b0;
      ovr_r <= 1'b0;
      auto_off_r <= 1'b1;
      mode_r <= uart_rx_pkg::MODE_RST;
    end else begin
      if (wr_a && st_a && wb_sel_i[1]) ien_r <= wb_dat_i[uart_rx_pkg::IEN_BIT];
      if (rd_a && st_a && wb_dat_o[uart_rx_pkg::OVR_BIT]) ovr_r <= 1'b1;
      if (wr_a && st_a && wb_sel_i[0] && !wb_dat_i[uart_rx_pkg::OVR_BIT]) ovr_r <= 1'b0;
      if (wr_a && md_a && wb_sel_i[0]) mode_r[7:0] <= wb_dat_i[7:0];
      if (wr_a && md_a && wb_sel_i[1]) mode_r[15:8] <= wb_dat_i[15:8];
      if (wr_a && md_a && wb_sel_i[0]) auto_off_r <= !wb_dat_i[uart_rx_pkg::AUTO_BIT];
      if (rd_a && md_a && !wb_dat_o[uart_rx_pkg::AUTO_BIT]) auto_off_r <= 1'b1;
    end
  end
  // All checks share the bus clock and its reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_follows_req_a: assert property (req_s |=> answer_s) else $error("ack not one cycle after request");
  ack_only_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o) else $error("outputs active after reset");
  unmapped_zero_a: assert property (rd_a && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0) else $error("hole not zero");
  mode_readback_a: assert property (rd_a && md_a |-> (wb_dat_o & 32'h801F) == (mode_r & 32'h801F))
    else $error("mode field lost");
  overrun_sticky_a: assert property (rd_a && st_a && ovr_r |-> wb_dat_o[uart_rx_pkg::OVR_BIT])
    else $error("overrun cleared by hardware");
  auto_stays_clear_a: assert property (rd_a && md_a && auto_off_r |-> !wb_dat_o[uart_rx_pkg::AUTO_BIT])
    else $error("auto rate set by hardware");
  irq_gated_a: assert property (!ien_r && !wb_ack_o |-> !irq_o) else $error("irq while disabled");
endmodule : uart_rx_mode_status_properties
bind uart_rx_mode_status uart_rx_mode_status_properties uart_rx_mode_status_properties_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .serial_rx_line_i(serial_rx_line_i), .irq_o(irq_o));

// ---- tb/uart_rx_mode_status_test.sv ----
// Self-checking bench for the receive mode and status block.
// Assumes the checker is bound by its own file and one remote transmitter.
`timescale 1ns/1ps
module uart_rx_mode_status_test;
  localparam int          BITC = 32;
  localparam logic [31:0] DSTD = 32'(BITC / uart_rx_pkg::OVS_STD - 1);
  localparam logic [31:0] DFST = 32'(BITC / uart_rx_pkg::OVS_FAST - 1);
  localparam logic [31:0] ON = 32'h1 << uart_rx_pkg::ON_BIT, AU = 32'h1 << uart_rx_pkg::AUTO_BIT;
  localparam logic [31:0] INV = 32'h1 << uart_rx_pkg::INV_BIT, FST = 32'h1 << uart_rx_pkg::FAST_BIT;
  localparam logic [31:0] ST2 = 32'h1 << uart_rx_pkg::STOP_BIT, F9 = 32'h3 << uart_rx_pkg::FMT_LSB;
  localparam logic [31:0] AV = 32'h1 << uart_rx_pkg::AVAIL_BIT, OV = 32'h1 << uart_rx_pkg::OVR_BIT;
  localparam logic [31:0] FE = 32'h1 << uart_rx_pkg::FRAME_BIT, PE = 32'h1 << uart_rx_pkg::PAR_BIT;
  localparam logic [31:0] ID = 32'h1 << uart_rx_pkg::IDLE_BIT, AD = 32'h1 << uart_rx_pkg::ADDR_BIT;
  localparam logic [31:0] IE = 32'h1 << uart_rx_pkg::IEN_BIT;
  localparam logic [3:0]  MD = uart_rx_pkg::MODE_ADDR, ST = uart_rx_pkg::STATUS_ADDR;
  localparam logic [3:0]  DT = uart_rx_pkg::DATA_ADDR, DV = uart_rx_pkg::DIV_ADDR;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, inv = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, q, rdat;
  logic        ack, irq, line;
  int          errors = 0, samples_checked = 0;
  int          need [3] = '{1, uart_rx_pkg::FILL_HALF, uart_rx_pkg::FILL_3Q};
  always #5 clk_i = ~clk_i;
  uart_rx_mode_status uart_rx_mode_status_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_rx_line_i(line), .irq_o(irq));
  serial_tx_model #(.BIT_CLKS(BITC)) serial_tx_model_inst (.clk_i(clk_i), .invert_i(inv), .line_o(line));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // One classic cycle; the request stands until ack is sampled, read data is taken at that edge.
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask : wb
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_flag(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask : chk_flag
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hF, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 4'hF, 32'h0);
    chk_word(q & m, e);
  endtask : rd
  // Half a bit of idle after each frame lets a late push land before anything is sampled.
  task automatic tx(input logic [8:0] d, input int nb, input int pm, input int st);
    serial_tx_model_inst.send(d, nb, pm, st);
    repeat (BITC / 2) @(posedge clk_i);
  endtask : tx
  // Main sequence; each group leaves the buffer empty for the next.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(MD, 32'hFFFF_FFFF, uart_rx_pkg::MODE_RST);
    rd(ST, ID | AV | OV | PE | FE, ID);
    rd(DV, 32'hFFFF, {16'h0, uart_rx_pkg::DIV_RST});
    rd(4'h2, 32'hFFFF_FFFF, 32'h0);
    wr(DV, DSTD);
    for (int f = 0; f < 3; f++) begin
      wr(MD, ON | (32'(f) << uart_rx_pkg::FMT_LSB));
      tx(9'h0A5, 8, f, 1);
      rd(ST, AV | PE | FE, AV);
      rd(DT, 32'h1FF, 32'h0A5);
      rd(ST, AV, 32'h0);
    end
    tx(9'h0A5, 8, 1, 1);
    rd(ST, PE | FE, PE);
    rd(DT, 32'h1FF, 32'h0A5);
    tx(9'h0A5, 8, 2, 0);
    rd(ST, PE | FE, FE);
    rd(DT, 32'h1FF, 32'h0A5);
    $display("test format and errors done");
    wr(ST, AD);
    wr(MD, ON);
    tx(9'h0AA, 8, 0, 1);
    rd(DT, 32'h1FF, 32'h0AA);
    wr(MD, ON | ST2 | F9);
    tx(9'h0AA, 9, 0, 2);
    tx(9'h155, 9, 0, 2);
    rd(DT, 32'h1FF, 32'h155);
    rd(ST, AV, 32'h0);
    wr(MD, ON | ST2);
    // One good stop, then a low bit where the second stop belongs; the line then rests high.
    serial_tx_model_inst.send(9'h0A5, 8, 0, 1);
    serial_tx_model_inst.put(1'b0);
    serial_tx_model_inst.put(1'b1);
    rd(ST, FE, FE);
    rd(DT, 32'h1FF, 32'h0A5);
    $display("test address and stop done");
    wr(ST, 32'h0);
    wr(MD, INV);
    inv <= 1'b1;
    wr(MD, ON | INV);
    fork
      tx(9'h03C, 8, 0, 1);
    join_none
    repeat (100) @(posedge clk_i);
    rd(ST, ID, 32'h0);
    wait fork;
    rd(ST, ID | AV, ID | AV);
    rd(DT, 32'h1FF, 32'h03C);
    wr(MD, 32'h0);
    inv <= 1'b0;
    wr(DV, DFST);
    wr(MD, ON | FST);
    tx(9'h0C3, 8, 0, 1);
    rd(DT, 32'h1FF, 32'h0C3);
    $display("test polarity and speed done");
    wr(DV, DSTD);
    wr(MD, ON);
    for (int t = 0; t < 3; t++) begin
      wr(ST, IE | (32'(t) << uart_rx_pkg::THR_LSB));
      for (int i = 1; i <= 9; i++) begin
        tx(9'(i), 8, 0, 1);
        chk_flag(irq, i >= need[t]);
      end
    end
    for (int i = 1; i <= 8; i++) rd(DT, 32'h1FF, 32'(i));
    rd(ST, OV | AV, OV);
    wb(1'b1, ST, 4'h1, 32'h2 << uart_rx_pkg::THR_LSB);
    rd(ST, OV | AV, 32'h0);
    chk_flag(irq, 1'b0);
    $display("test threshold and overrun done");
    // Start from a wrong divider so that only a real measurement can restore it.
    wr(DV, DFST);
    wr(MD, ON | AU);
    tx({1'b0, uart_rx_pkg::SYNC_CHAR}, 8, 0, 1);
    rd(MD, AU, 32'h0);
    rd(DV, 32'hFFFF, DSTD);
    $display("test auto rate done");
    finish_test();
  end
endmodule : uart_rx_mode_status_test
